// ===== inc/bdalu_pkg.sv
// constants, flag layout and operation codes for the bcd adjust / decrement alu slice
// assumes a single 40 MHz core clock and a register file with a same-cycle read path
// How it works
// - decimal adjust adds 6 to the accumulator low nibble when it is above 9 or digit carry is set.
// - decimal adjust adds 6 to the accumulator high nibble when it is above 9 or carry is set.
// - decrement takes one from the addressed file register and delivers the 8-bit result.
// - destination select 0 sends the decrement result to the accumulator, 1 back to the file.
// - bank access 0 uses the access bank and ignores the bank select register, 1 uses it.
package bdalu_pkg;

  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam int FLAG_W = 5;

  // flag vector bit positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  // reset values
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h00;

  // nibble correction
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [3:0] BCD_ADJUST = 4'h6;

  // access bank split: low half maps to bank 0, high half to the top bank
  localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW   = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH  = 4'hF;

  // decrement constants
  localparam logic [DATA_W-1:0] DEC_ONE     = 8'h01;
  localparam logic [DATA_W-1:0] DEC_OV_EDGE = 8'h80;

  // destination and bank access encodings
  localparam logic DEST_ACC    = 1'b0;
  localparam logic ACCESS_BANK = 1'b0;

  typedef enum logic {
    BDALU_OP_ADJUST = 1'b0,
    BDALU_OP_DEC    = 1'b1
  } bdalu_op_type;

  typedef enum logic {
    BDALU_IDLE = 1'b0,
    BDALU_EXEC = 1'b1
  } bdalu_state_type;

endpackage

// ===== logic/bdalu_core.sv
// alu slice: decimal adjust of the accumulator and decrement of a file register
// assumes the register file answers o_file_addr combinationally on i_file_rdata
// and that the decoder pulses i_start only while o_busy is low
`timescale 1ns/1ps
module bdalu_core
  import bdalu_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // operation request from the decoder
  input  wire logic              i_start,
  input  wire logic              i_op_dec,
  input  wire logic [DATA_W-1:0] i_file_sel,
  input  wire logic              i_dest_sel,
  input  wire logic              i_bank_access,
  input  wire logic [BANK_W-1:0] i_bank_select_register,
  // register file port
  input  wire logic [DATA_W-1:0] i_file_rdata,
  output logic      [ADDR_W-1:0] o_file_addr,
  output logic      [DATA_W-1:0] o_file_wdata,
  output logic                   o_file_we,
  // direct loads of accumulator and flags by the rest of the core
  input  wire logic              i_acc_we,
  input  wire logic [DATA_W-1:0] i_acc_wdata,
  input  wire logic              i_flags_we,
  input  wire logic [FLAG_W-1:0] i_flags_wdata,
  // state
  output logic      [DATA_W-1:0] o_acc,
  output logic                   o_carry,
  output logic                   o_digit_carry_flag,
  output logic                   o_zero,
  output logic                   o_overflow,
  output logic                   o_negative,
  output logic                   o_busy,
  output logic                   o_done
);

  bdalu_state_type state;
  bdalu_state_type next_state;
  bdalu_op_type    op;
  logic            dest;
  logic [DATA_W-1:0] acc;
  logic [FLAG_W-1:0] flags;
  logic [ADDR_W-1:0] file_addr;
  logic [DATA_W-1:0] file_wdata;
  logic              file_we;
  logic              done;

  // address formation
  wire [BANK_W-1:0] access_bank;
  wire [BANK_W-1:0] bank;
  wire [ADDR_W-1:0] next_addr;

  assign access_bank = (i_file_sel < ACCESS_SPLIT) ? ACCESS_LOW : ACCESS_HIGH;
  assign bank        = (i_bank_access == ACCESS_BANK) ? access_bank
                                                       : i_bank_select_register;
  assign next_addr   = {bank, i_file_sel};

  // decimal adjust path
  wire [3:0] adj_lo;
  wire [3:0] adj_hi;
  wire       lo_carry;
  wire       hi_carry;
  wire [DATA_W-1:0] adj_result;

  bdalu_nibble u_lo (
    .i_nibble (acc[3:0]),
    .i_force  (flags[FLAG_DC]),
    .i_carry  (1'b0),
    .o_nibble (adj_lo),
    .o_carry  (lo_carry)
  );

  // high nibble is judged on its original value; the low carry still ripples in
  bdalu_nibble u_hi (
    .i_nibble (acc[7:4]),
    .i_force  (flags[FLAG_C]),
    .i_carry  (lo_carry),
    .o_nibble (adj_hi),
    .o_carry  (hi_carry)
  );

  assign adj_result = {adj_hi, adj_lo};

  // decrement path
  wire [DATA_W:0]   dec_sum;
  wire [DATA_W-1:0] dec_result;
  wire              dec_c;
  wire              dec_dc;
  wire              dec_ov;

  assign dec_sum    = {1'b0, i_file_rdata} - {1'b0, DEC_ONE};
  assign dec_result = dec_sum[DATA_W-1:0];
  // carry and digit carry mean no borrow
  assign dec_c      = ~dec_sum[DATA_W];
  assign dec_dc     = (i_file_rdata[3:0] != 4'h0);
  assign dec_ov     = (i_file_rdata == DEC_OV_EDGE);

  wire [FLAG_W-1:0] dec_flags;
  assign dec_flags = {dec_result[DATA_W-1], dec_ov, (dec_result == 8'h00),
                      dec_dc, dec_c};

  wire [FLAG_W-1:0] adj_flags;
  assign adj_flags = {flags[FLAG_W-1:1], hi_carry};

  // result steering
  wire exec;
  wire exec_dec;
  wire dec_to_acc;
  wire dec_to_file;

  assign exec        = (state == BDALU_EXEC);
  assign exec_dec    = exec & (op == BDALU_OP_DEC);
  assign dec_to_acc  = exec_dec & (dest == DEST_ACC);
  assign dec_to_file = exec_dec & (dest != DEST_ACC);

  logic [DATA_W-1:0] next_acc;
  logic [FLAG_W-1:0] next_flags;

  // alu results win over a same-cycle direct load from the core
  always_comb begin
    next_acc   = acc;
    next_flags = flags;
    if (i_acc_we) begin
      next_acc = i_acc_wdata;
    end
    if (i_flags_we) begin
      next_flags = i_flags_wdata;
    end
    if (exec && op == BDALU_OP_ADJUST) begin
      next_acc   = adj_result;
      next_flags = adj_flags;
    end
    if (dec_to_acc) begin
      next_acc = dec_result;
    end
    if (exec_dec) begin
      next_flags = dec_flags;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      BDALU_IDLE: begin
        if (i_start) begin
          next_state = BDALU_EXEC;
        end
      end
      BDALU_EXEC: begin
        next_state = BDALU_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= BDALU_IDLE;
      op    <= BDALU_OP_ADJUST;
      dest  <= 1'b1;
    end else begin
      state <= next_state;
      if (state == BDALU_IDLE && i_start) begin
        op   <= i_op_dec ? BDALU_OP_DEC : BDALU_OP_ADJUST;
        dest <= i_dest_sel;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      file_addr <= '0;
    end else if (state == BDALU_IDLE && i_start) begin
      file_addr <= next_addr;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      acc   <= ACC_RESET;
      flags <= FLAG_RESET;
    end else begin
      acc   <= next_acc;
      flags <= next_flags;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      file_wdata <= '0;
      file_we    <= 1'b0;
      done       <= 1'b0;
    end else begin
      file_we <= dec_to_file;
      done    <= exec;
      if (dec_to_file) begin
        file_wdata <= dec_result;
      end
    end
  end

  assign o_file_addr        = file_addr;
  assign o_file_wdata       = file_wdata;
  assign o_file_we          = file_we;
  assign o_acc              = acc;
  assign o_carry            = flags[FLAG_C];
  assign o_digit_carry_flag = flags[FLAG_DC];
  assign o_zero             = flags[FLAG_Z];
  assign o_overflow         = flags[FLAG_OV];
  assign o_negative         = flags[FLAG_N];
  assign o_busy             = exec;
  assign o_done             = done;

endmodule

// ===== logic/bdalu_nibble.sv
// one bcd nibble correction stage with carry in and carry out
// assumes purely combinational use inside the alu slice
`timescale 1ns/1ps
module bdalu_nibble
  import bdalu_pkg::*;
(
  // nibble in
  input  wire logic [3:0] i_nibble,
  input  wire logic       i_force,
  input  wire logic       i_carry,
  // corrected nibble out
  output logic      [3:0] o_nibble,
  output logic            o_carry
);

  wire       do_adjust;
  wire [4:0] sum;

  assign do_adjust = (i_nibble > BCD_MAX) | i_force;
  assign sum       = {1'b0, i_nibble} + {1'b0, (do_adjust ? BCD_ADJUST : 4'h0)}
                     + {4'h0, i_carry};
  assign o_nibble  = sum[3:0];
  assign o_carry   = sum[4];

endmodule

// ===== test/bdalu_core_properties.sv
// port-level checker for the bcd adjust / decrement alu slice
// assumes it is bound onto bdalu_core and sees only its ports
`timescale 1ns/1ps
module bdalu_core_properties
  import bdalu_pkg::*;
(
  input wire logic              i_clk_sys,
  input wire logic              i_resetn,
  input wire logic              i_start,
  input wire logic              i_op_dec,
  input wire logic [DATA_W-1:0] i_file_sel,
  input wire logic              i_dest_sel,
  input wire logic              i_bank_access,
  input wire logic [BANK_W-1:0] i_bank_select_register,
  input wire logic [DATA_W-1:0] i_file_rdata,
  input wire logic              i_flags_we,
  input wire logic [ADDR_W-1:0] o_file_addr,
  input wire logic [DATA_W-1:0] o_file_wdata,
  input wire logic              o_file_we,
  input wire logic [DATA_W-1:0] o_acc,
  input wire logic              o_carry,
  input wire logic              o_zero,
  input wire logic              o_busy,
  input wire logic              o_done
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire go = i_start && !o_busy;
  busy_after_go_a: assert property (go |=> o_busy) else $error("busy missing after start");
  done_after_exec_a: assert property (o_busy |=> o_done && !o_busy) else $error("no done after exec");
  file_write_dest_a: assert property (go && i_op_dec && i_dest_sel |=> ##1 o_file_we)
    else $error("file write missing");
  acc_dest_value_a: assert property (go && i_op_dec && !i_dest_sel |=> ##1
    !o_file_we && o_acc == $past(i_file_rdata) - 8'h01) else $error("acc result wrong");
  file_wdata_value_a: assert property (o_file_we |-> o_file_wdata == $past(i_file_rdata) - 8'h01)
    else $error("file data wrong");
  bank_select_addr_a: assert property (go && i_bank_access |=>
    o_file_addr == {$past(i_bank_select_register), $past(i_file_sel)}) else $error("bank addr wrong");
  access_bank_addr_a: assert property (go && !i_bank_access |=>
    o_file_addr == {{4{$past(i_file_sel[7])}}, $past(i_file_sel)}) else $error("access addr wrong");
  dec_flags_a: assert property (go && i_op_dec |=> ##1 o_carry == ($past(i_file_rdata) != 8'h00)
    && o_zero == ($past(i_file_rdata) == 8'h01)) else $error("decrement flags wrong");
  adjust_keeps_zero_a: assert property ((go && !i_op_dec) ##1 !i_flags_we |=> $stable(o_zero))
    else $error("adjust touched zero");
  cover property (go && !i_op_dec);
  cover property (o_file_we);
  refused_start_a: assert property (i_start && o_busy |=> !o_busy && $stable(o_file_addr))
    else $error("start taken while busy");
  cover property (go && i_op_dec && !i_dest_sel);
  cover property (i_start && o_busy);
endmodule

// ===== test/testbench.sv
// self-checking bench for bdalu_core: corner cases then lfsr-driven operations
// assumes the bench plays decoder and register file, driving at the falling edge
`timescale 1ns/1ps
module testbench
  import bdalu_pkg::*;
;
  logic        i_clk_sys, i_resetn, i_start, i_op_dec, i_dest_sel, i_bank_access;
  logic        i_acc_we, i_flags_we, o_file_we, o_carry, o_digit_carry_flag;
  logic        o_zero, o_overflow, o_negative, o_busy, o_done;
  logic [7:0]  i_file_sel, i_file_rdata, i_acc_wdata, o_file_wdata, o_acc;
  logic [3:0]  i_bank_select_register;
  logic [4:0]  i_flags_wdata;
  logic [11:0] o_file_addr;
  logic [31:0] seed;
  int          bad_count, n_compared, cyc;
  bdalu_core bdalu_core_i (.*);
  initial begin
    i_clk_sys = 1'h0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one operation: preload acc and flags, start, supply file data, check results
  task automatic run(input logic dec, input logic [7:0] v, input logic [4:0] fl, input logic d,
                     input logic a, input logic [3:0] b, input logic [7:0] f);
    logic [4:0]  lo, hi;
    logic [7:0]  r;
    logic [11:0] ad;
    lo = v[3:0] + ((v[3:0] > 4'h9 || fl[FLAG_DC]) ? 5'h06 : 5'h00);
    hi = v[7:4] + ((v[7:4] > 4'h9 || fl[FLAG_C]) ? 5'h06 : 5'h00) + lo[4];
    r = v - 8'h01;
    ad = a ? {b, f} : {f[7] ? ACCESS_HIGH : ACCESS_LOW, f};
    i_acc_we = 1'h1;
    i_acc_wdata = dec ? ~v : v;
    i_flags_we = 1'h1;
    i_flags_wdata = fl;
    @(negedge i_clk_sys);
    {i_acc_we, i_flags_we, i_start, i_op_dec, i_file_sel} = {3'h1, dec, f};
    {i_dest_sel, i_bank_access, i_bank_select_register} = {d, a, b};
    @(negedge i_clk_sys);
    // a start raised in the busy cycle must be refused and leave the address alone
    i_start = v[0] ^ f[0];
    i_file_sel = ~f;
    i_file_rdata = v;
    chk(12'(o_busy), 12'h001);
    chk(o_file_addr, ad);
    @(negedge i_clk_sys);
    i_start = 1'h0;
    i_file_rdata = ~v;
    chk(12'({o_busy, o_done}), 12'h001);
    chk(o_file_addr, ad);
    if (!dec) begin
      chk(12'({hi[3:0], lo[3:0]}), 12'({hi[3:0], lo[3:0]}) & 12'(o_acc) | 12'(o_acc) & 12'h000
          | 12'(o_acc));
      chk(12'(o_acc), 12'({hi[3:0], lo[3:0]}));
      chk(12'({o_file_we, o_carry, o_zero}), 12'({1'h0, hi[4], fl[FLAG_Z]}));
    end else begin
      chk(12'(o_acc), {4'h0, (d ? ~v : r)});
      chk(12'(o_file_we), 12'(d));
      if (d) chk(12'(o_file_wdata), 12'(r));
      chk(12'({o_negative, o_overflow, o_zero, o_digit_carry_flag, o_carry}),
          12'({r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00}));
    end
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    {i_resetn, i_start, i_op_dec, i_dest_sel, i_bank_access, i_acc_we, i_flags_we} = 7'h00;
    {i_file_sel, i_file_rdata, i_acc_wdata} = 24'h000000;
    {i_bank_select_register, i_flags_wdata} = 9'h000;
    seed = 32'h00000F2C;
    repeat (12) @(negedge i_clk_sys);
    i_resetn = 1'h1;
    run(1'h0, 8'hA5, 5'h00, 1'h0, 1'h0, 4'h0, 8'h00);
    run(1'h0, 8'hCE, 5'h04, 1'h0, 1'h0, 4'h0, 8'h00);
    run(1'h0, 8'h99, 5'h03, 1'h0, 1'h0, 4'h0, 8'h00);
    run(1'h1, 8'h00, 5'h1F, 1'h1, 1'h0, 4'h3, 8'h7F);
    run(1'h1, 8'h80, 5'h00, 1'h0, 1'h0, 4'h3, 8'h80);
    run(1'h1, 8'h01, 5'h00, 1'h1, 1'h1, 4'h5, 8'h12);
    // mid-run reset: every output returns to zero at once
    i_resetn = 1'h0;
    @(negedge i_clk_sys);
    chk(12'(o_acc), 12'h000);
    chk(o_file_addr, 12'h000);
    chk(12'(o_file_wdata), 12'h000);
    chk(12'({o_carry, o_digit_carry_flag, o_zero, o_overflow, o_negative, o_file_we,
             o_busy, o_done}), 12'h000);
    i_resetn = 1'h1;
    repeat (300) begin
      seed = lfsr(seed);
      run(seed[0], seed[15:8], seed[20:16], seed[1], seed[2], seed[7:4], seed[31:24]);
    end
    report_and_stop;
  end
endmodule
bind bdalu_core bdalu_core_properties bdalu_core_properties_i (.*);
